// >>> inc/irc_pkg.sv
package irc_pkg;
	localparam int          PHASES        = 4;     // clock cycles per machine cycle
	localparam int          RESET_MCYCLES = 4;     // least reset length in machine cycles
	localparam int          RESET_CLOCKS  = RESET_MCYCLES * PHASES;
	localparam int          PC_W          = 11;
	localparam int          STACK_DEPTH   = 3;
	localparam logic [10:0] PC_RESET      = 11'h000;
	localparam logic [10:0] INT_VECTOR    = 11'h03C;
	localparam int          OUT_LINES     = 27;
	localparam logic [OUT_LINES-1:0] OUT_OE_RESET = 27'h7FFFFFF; // oe high = released

	typedef enum logic [1:0] {
		IRC_T1 = 2'b00,
		IRC_T2 = 2'b01,
		IRC_T3 = 2'b10,
		IRC_T4 = 2'b11
	} irc_phase_t;

	// instruction control strobes from the decoder
	typedef struct packed {
		logic       lastCycle;   // final machine cycle of current instruction
		logic       firstCycle;  // first machine cycle of current instruction
		logic       enableInt;   // enable_interrupt_op
		logic       maskInt;     // mask_interrupt_op
		logic       testClear;   // test_clear_pending_op
		logic       subExit;     // subroutine_exit_op
		logic       clearAcc;    // clear_accumulator_op
		logic       loadImm;     // load_immediate_op
		logic       call;        // ordinary call push
		logic       jump;        // ordinary jump load
	} irc_ctl_t;
endpackage

// >>> hdl/irc_interrupt_reset_control.sv
`timescale 1ns/1ps
// Function
// - one machine cycle is exactly four oscillator clock cycles.
// - reset loads program counter zero and clears pending and enable flags.
// - during reset all open-drain output transistors are switched off.
// - after reset releases, fetching starts at program address zero.
// - falling edge on interrupt request sets the pending flag.
// - pending flag clears on acceptance and on test-and-clear instruction.
// - enable set only by enable op, cleared by mask op or acceptance.
// - flags act independently; disabled enable flag blocks interrupts.
// - sample pending in last clock of instruction; take if enabled.
// - acceptance pushes next address, loads vector 03C, clears both flags.
// - multi-cycle instructions sample only at end of final machine cycle.
// - clear-accumulator and load-immediate instructions never accept interrupts.
// - test-and-clear clears pending at T3 of first cycle, skips if set.
// - request after that clear sets pending again, sampled at T4.
// - no acceptance during enable op; enable takes effect next instruction.
// - subroutine exit pops most recent return address into program counter.
module irc_interrupt_reset_control #(
	parameter int PC_W  = irc_pkg::PC_W,
	parameter int DEPTH = irc_pkg::STACK_DEPTH
) (
	input  wire logic                          ref_clk,
	input  wire logic                          nrst,
	input  wire logic                          chipClearIn,
	input  wire logic                          intReqN,
	input  wire irc_pkg::irc_ctl_t             ctl,
	input  wire logic [PC_W-1:0]               nextPc,
	input  wire logic [PC_W-1:0]               targetPc,
	output irc_pkg::irc_phase_t                phase,
	output logic                               mcycleEnd,
	output logic                               instrEnd,
	output logic [PC_W-1:0]                    programCounter,
	output logic                               intPending,
	output logic                               interruptEnableFlag,
	output logic                               intAccept,
	output logic                               skipNext,
	output logic [irc_pkg::OUT_LINES-1:0]      outReleaseOe,
	output logic                               coreRun
);
	irc_pkg::irc_phase_t phase_q;
	logic                clr;
	logic                reqS1_q;
	logic                reqS2_q;
	logic                reqS3_q;
	logic                fall;
	logic                pend_q;
	logic                ena_q;
	logic                enaPend_q;
	logic                skip_q;
	logic [PC_W-1:0]     pc_q;
	logic [PC_W-1:0]     stack_q [DEPTH];
	logic                take;
	logic                tcClear;

	// both the pin reset and the core reset put the block in reset, except the request synchroniser, which only the pin reset clears
	assign clr = !nrst || chipClearIn;

	// phase counter T1..T4
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			phase_q <= irc_pkg::IRC_T1;
		end else begin
			phase_q <= irc_pkg::irc_phase_t'(phase_q + 2'h1);
		end
	end

	assign phase     = phase_q;
	assign mcycleEnd = !clr && (phase_q == irc_pkg::IRC_T4);
	assign instrEnd  = mcycleEnd && ctl.lastCycle;

	// request synchroniser; first stage feeds only the second
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			reqS1_q <= 1'b1;
			reqS2_q <= 1'b1;
			reqS3_q <= 1'b1;
		end else begin
			reqS1_q <= intReqN;
			reqS2_q <= reqS1_q;
			reqS3_q <= reqS2_q;
		end
	end

	assign fall = reqS3_q && !reqS2_q;

	// test-and-clear strobes its clear at T3 of its first machine cycle
	assign tcClear = ctl.testClear && ctl.firstCycle && (phase_q == irc_pkg::IRC_T3);

	// acceptance at end of last cycle; blocked by enable op and by clear-accumulator and load-immediate ops
	assign take = instrEnd && pend_q && ena_q && !ctl.enableInt
		&& !ctl.clearAcc && !ctl.loadImm;

	assign intAccept = take;

	// pending flag: a new edge wins over acceptance or test-and-clear in the same cycle; reset wins over it
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			pend_q <= 1'b0;
		end else if (fall) begin
			pend_q <= 1'b1;
		end else if (take || tcClear) begin
			pend_q <= 1'b0;
		end
	end

	// skip decision taken from the flag value just before the clear;
	// it must outlive the test-and-clear itself to cover the next instruction
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			skip_q <= 1'b0;
		end else if (tcClear) begin
			skip_q <= pend_q;
		end else if (instrEnd && !ctl.testClear) begin
			skip_q <= 1'b0;
		end
	end

	assign skipNext = skip_q;

	// enable flag; enable op arms it, it lands at start of next instruction
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			ena_q     <= 1'b0;
			enaPend_q <= 1'b0;
		end else if (take) begin
			ena_q     <= 1'b0;
			enaPend_q <= 1'b0;
		end else if (instrEnd && ctl.maskInt) begin
			ena_q     <= 1'b0;
			enaPend_q <= 1'b0;
		end else if (instrEnd && ctl.enableInt) begin
			enaPend_q <= 1'b1;
		end else if (enaPend_q) begin
			ena_q     <= 1'b1;
			enaPend_q <= 1'b0;
		end
	end

	// program counter and return stack
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			pc_q <= PC_W'(irc_pkg::PC_RESET);
			for (int i = 0; i < DEPTH; i++) begin
				stack_q[i] <= '0;
			end
		end else if (take) begin
			pc_q       <= PC_W'(irc_pkg::INT_VECTOR);
			stack_q[0] <= nextPc;
			for (int i = 1; i < DEPTH; i++) begin
				stack_q[i] <= stack_q[i-1];
			end
		end else if (instrEnd && ctl.subExit) begin
			pc_q <= stack_q[0];
			for (int i = 0; i < DEPTH - 1; i++) begin
				stack_q[i] <= stack_q[i+1];
			end
		end else if (instrEnd && ctl.call) begin
			pc_q       <= targetPc;
			stack_q[0] <= nextPc;
			for (int i = 1; i < DEPTH; i++) begin
				stack_q[i] <= stack_q[i-1];
			end
		end else if (instrEnd) begin
			pc_q <= ctl.jump ? targetPc : nextPc;
		end
	end

	assign programCounter      = pc_q;
	assign intPending          = pend_q;
	assign interruptEnableFlag = ena_q;

	// outputs released (oe high) while in reset; port logic owns them after
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			outReleaseOe <= irc_pkg::OUT_OE_RESET;
			coreRun      <= 1'b0;
		end else begin
			outReleaseOe <= '0;
			coreRun      <= 1'b1;
		end
	end

	// ---- checks
	sequence s_tcClear;
		ctl.testClear && ctl.firstCycle && phase_q == irc_pkg::IRC_T3;
	endsequence

	property p_phaseWrap;
		@(posedge ref_clk) disable iff (clr)
		phase_q == irc_pkg::IRC_T1 |=> phase_q == irc_pkg::IRC_T2 ##1
			phase_q == irc_pkg::IRC_T3 ##1 phase_q == irc_pkg::IRC_T4;
	endproperty
	a_phaseWrap: assert property (p_phaseWrap) else $error("phase sequence broken");

	property p_resetState;
		@(posedge ref_clk) clr |=> pc_q == '0 && !pend_q && !ena_q && &outReleaseOe
			&& phase_q == irc_pkg::IRC_T1;
	endproperty
	a_resetState: assert property (p_resetState) else $error("reset state wrong");

	property p_oeReset;
		@(posedge ref_clk) clr |=> outReleaseOe == irc_pkg::OUT_OE_RESET;
	endproperty
	a_oeReset: assert property (p_oeReset) else $error("outputs not released");

	property p_fallSets;
		@(posedge ref_clk) disable iff (clr) fall |=> pend_q;
	endproperty
	a_fallSets: assert property (p_fallSets) else $error("edge lost");

	property p_takeVector;
		@(posedge ref_clk) disable iff (clr)
		take |=> pc_q == PC_W'(irc_pkg::INT_VECTOR) && !ena_q && stack_q[0] == $past(nextPc);
	endproperty
	a_takeVector: assert property (p_takeVector) else $error("vector entry wrong");

	property p_noTakeOutsideEnd;
		@(posedge ref_clk) disable iff (clr) take |-> mcycleEnd && ctl.lastCycle;
	endproperty
	a_noTakeOutsideEnd: assert property (p_noTakeOutsideEnd) else $error("early take");

	property p_noTakeLoad;
		@(posedge ref_clk) disable iff (clr)
		(ctl.clearAcc || ctl.loadImm || ctl.enableInt || !ena_q) |-> !take;
	endproperty
	a_noTakeLoad: assert property (p_noTakeLoad) else $error("blocked take");

	property p_tcClears;
		@(posedge ref_clk) disable iff (clr)
		s_tcClear and !fall |=> !pend_q && skip_q == $past(pend_q);
	endproperty
	a_tcClears: assert property (p_tcClears) else $error("test-clear wrong");

	property p_enaDelayed;
		@(posedge ref_clk) disable iff (clr)
		instrEnd && ctl.enableInt && !ena_q && !take |=> !ena_q ##1 ena_q;
	endproperty
	a_enaDelayed: assert property (p_enaDelayed) else $error("enable timing");

	property p_popExit;
		@(posedge ref_clk) disable iff (clr)
		instrEnd && ctl.subExit && !take |=> pc_q == $past(stack_q[0]);
	endproperty
	a_popExit: assert property (p_popExit) else $error("return pop wrong");

	// reset held for one edge, then released
	sequence s_release;
		clr ##1 !clr;
	endsequence

	// synchronised pin seen high, then low
	sequence s_pinFall;
		reqS1_q ##1 !reqS1_q;
	endsequence

	// phase restarts at T1 on the first cycle out of reset
	property p_phaseReset;
		@(posedge ref_clk)
		s_release |-> phase_q == irc_pkg::IRC_T1;
	endproperty
	a_phaseReset: assert property (p_phaseReset) else $error("phase not restarted");

	// core starts at address zero in the cycle it begins to run
	property p_startAtZero;
		@(posedge ref_clk) disable iff (clr)
		$rose(coreRun) |-> pc_q == PC_W'(irc_pkg::PC_RESET) && phase_q == irc_pkg::IRC_T2;
	endproperty
	a_startAtZero: assert property (p_startAtZero) else $error("start address wrong");

	// outputs handed back to port logic once out of reset
	property p_coreRun;
		@(posedge ref_clk)
		!clr |=> coreRun && outReleaseOe == '0;
	endproperty
	a_coreRun: assert property (p_coreRun) else $error("core not running");

	// a pin fall reaches the edge detector one cycle after the first stage
	property p_syncFall;
		@(posedge ref_clk) disable iff (!nrst)
		s_pinFall |=> fall;
	endproperty
	a_syncFall: assert property (p_syncFall) else $error("edge not detected");

	// one fall gives one strobe, so the flag is set once
	property p_fallOnce;
		@(posedge ref_clk) disable iff (!nrst)
		fall |=> !fall;
	endproperty
	a_fallOnce: assert property (p_fallOnce) else $error("edge strobe too long");

	// pending never sets without a detected edge
	property p_pendNoSpurious;
		@(posedge ref_clk) disable iff (clr)
		!pend_q && !fall |=> !pend_q;
	endproperty
	a_pendNoSpurious: assert property (p_pendNoSpurious) else $error("spurious pending");

	// pending stays set whatever the enable flag does
	property p_pendHold;
		@(posedge ref_clk) disable iff (clr)
		pend_q && !take && !tcClear |=> pend_q;
	endproperty
	a_pendHold: assert property (p_pendHold) else $error("pending lost");

	// acceptance clears pending unless a new edge lands at once
	property p_takeClearsPend;
		@(posedge ref_clk) disable iff (clr)
		take && !fall |=> !pend_q;
	endproperty
	a_takeClearsPend: assert property (p_takeClearsPend) else $error("pending kept");

	// enable can only rise from an armed enable op
	property p_enaOnlyByOp;
		@(posedge ref_clk) disable iff (clr)
		$rose(ena_q) |-> $past(enaPend_q);
	endproperty
	a_enaOnlyByOp: assert property (p_enaOnlyByOp) else $error("enable set by itself");

	// mask op clears enable at its end
	property p_maskClears;
		@(posedge ref_clk) disable iff (clr)
		instrEnd && ctl.maskInt |=> !ena_q;
	endproperty
	a_maskClears: assert property (p_maskClears) else $error("mask ignored");

	// skip stays up through the end of the test-and-clear and beyond
	property p_skipHolds;
		@(posedge ref_clk) disable iff (clr)
		s_tcClear ##0 pend_q |=> skip_q [*4];
	endproperty
	a_skipHolds: assert property (p_skipHolds) else $error("skip dropped early");

	// skip is used up by the end of the following instruction
	property p_skipClears;
		@(posedge ref_clk) disable iff (clr)
		instrEnd && !ctl.testClear |=> !skip_q;
	endproperty
	a_skipClears: assert property (p_skipClears) else $error("skip not cleared");

	// older return addresses move down on acceptance
	property p_takePush;
		@(posedge ref_clk) disable iff (clr)
		take |=> stack_q[1] == $past(stack_q[0]);
	endproperty
	a_takePush: assert property (p_takePush) else $error("stack not pushed");

	// exit moves the older entries up
	property p_exitShift;
		@(posedge ref_clk) disable iff (clr)
		instrEnd && ctl.subExit && !take |=> stack_q[0] == $past(stack_q[1]);
	endproperty
	a_exitShift: assert property (p_exitShift) else $error("stack not popped");
endmodule

// >>> testbench/irc_request_source.sv
`timescale 1ns/1ps
module irc_request_source (
	input  wire logic ref_clk,
	output logic      intReqN,
	output logic      chipClearIn
);
	// request line idles high like a pulled-up open-drain input
	initial begin
		intReqN = 1'b1;
		chipClearIn = 1'b0;
	end

	// one falling edge per call, runs beside the caller
	task automatic fire(input int unsigned lowCycles);
		fork
			begin
				intReqN = 1'b0;
				repeat (lowCycles) @(posedge ref_clk);
				#1 intReqN = 1'b1;
			end
		join_none
	endtask

	// never shorter than the least reset length, even if asked
	task automatic hold_clear(input int unsigned clocks);
		chipClearIn = 1'b1;
		repeat ((clocks < irc_pkg::RESET_CLOCKS) ? irc_pkg::RESET_CLOCKS : clocks)
			@(posedge ref_clk);
		#1 chipClearIn = 1'b0;
	endtask
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam logic [9:0] OP_NONE = 10'h000;
	localparam logic [9:0] OP_ENA  = 10'h080;
	localparam logic [9:0] OP_MASK = 10'h040;
	localparam logic [9:0] OP_TCLR = 10'h020;
	localparam logic [9:0] OP_EXIT = 10'h010;
	localparam logic [9:0] OP_CACC = 10'h008;
	localparam logic [9:0] OP_LIMM = 10'h004;
	logic                            ref_clk = 1'b0;
	logic                            nrst = 1'b0;
	wire logic                       chipClearIn;
	wire logic                       intReqN;
	irc_pkg::irc_ctl_t               ctl = '0;
	logic [10:0]                     nextPc = 11'h000;
	irc_pkg::irc_phase_t             phase;
	logic                            mcycleEnd;
	logic                            instrEnd;
	logic [10:0]                     programCounter;
	logic                            intPending;
	logic                            interruptEnableFlag;
	logic                            intAccept;
	logic                            skipNext;
	logic [irc_pkg::OUT_LINES-1:0]   outReleaseOe;
	logic                            coreRun;
	logic                            expQ[$];
	int                              miscompares = 0;
	int                              cmpCount = 0;
	logic [10:0]                     pushA;
	logic [10:0]                     pushB;

	irc_request_source u_req (.ref_clk(ref_clk), .intReqN(intReqN), .chipClearIn(chipClearIn));

	irc_interrupt_reset_control u_dut (
		.ref_clk(ref_clk), .nrst(nrst), .chipClearIn(chipClearIn), .intReqN(intReqN),
		.ctl(ctl), .nextPc(nextPc), .targetPc(11'h000), .phase(phase),
		.mcycleEnd(mcycleEnd), .instrEnd(instrEnd), .programCounter(programCounter),
		.intPending(intPending), .interruptEnableFlag(interruptEnableFlag),
		.intAccept(intAccept), .skipNext(skipNext), .outReleaseOe(outReleaseOe),
		.coreRun(coreRun));

	// 25 ns period
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic step;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("compares=%0d mismatches=%0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// one instruction of n machine cycles, started at T1; accept outcome queued
	task automatic instr(input logic [9:0] op, input int n, input logic acc);
		int guard;
		guard = 0;
		while (phase !== irc_pkg::IRC_T1 && guard < 8) begin
			step();
			guard++;
		end
		if (guard == 8) begin
			miscompares++;
			report_and_stop();
		end
		nextPc = 11'($urandom);
		expQ.push_back(acc);
		for (int i = 0; i < n; i++) begin
			ctl = irc_pkg::irc_ctl_t'(op | {i == n - 1, i == 0, 8'h00});
			repeat (4) step();
		end
	endtask

	// instruction ends pop the oldest note; inner machine cycle ends never accept
	always @(posedge ref_clk) begin
		if (instrEnd === 1'b1) check(intAccept, (expQ.size() > 0) ? expQ.pop_front() : 1'b0);
		else if (mcycleEnd === 1'b1) check(intAccept, 1'b0);
	end

	initial begin
		void'($urandom(45));
		repeat (6) step();
		check(programCounter, 11'h000);
		check({intPending, interruptEnableFlag}, 2'h0);
		check(outReleaseOe, irc_pkg::OUT_OE_RESET);
		check({phase, coreRun}, 3'h0);
		nrst = 1'b1;
		step();
		check({phase, coreRun}, 3'h3);
		check(programCounter, 11'h000);
		check(outReleaseOe, 27'h0000000);
		// four clocks per machine cycle, end strobe only at the last phase
		for (int i = 0; i < 8; i++) begin
			check({phase, mcycleEnd}, {2'(i + 1), (i % 4) == 2});
			step();
		end
		// pending with enable off is ignored, then cleared by test-and-clear without acceptance
		u_req.fire(2 + $urandom % 4);
		instr(OP_NONE, 1, 1'b0);
		instr(OP_NONE, 1, 1'b0);
		check({intPending, interruptEnableFlag}, 2'h2);
		instr(OP_TCLR, 1, 1'b0);
		check({intPending, skipNext}, 2'h1);
		// enable takes hold one instruction late, then service
		u_req.fire(2 + $urandom % 4);
		instr(OP_NONE, 1, 1'b0);
		check(skipNext, 1'b0);
		instr(OP_ENA, 1, 1'b0);
		instr(OP_NONE, 1, 1'b1);
		pushA = nextPc;
		check(programCounter, irc_pkg::INT_VECTOR);
		check({intPending, interruptEnableFlag}, 2'h0);
		// excluded instructions, then a two-cycle instruction takes it
		instr(OP_ENA, 1, 1'b0);
		u_req.fire(3);
		instr(OP_CACC, 1, 1'b0);
		instr(OP_LIMM, 1, 1'b0);
		instr(OP_NONE, 2, 1'b1);
		pushB = nextPc;
		instr(OP_EXIT, 1, 1'b0);
		check(programCounter, pushB);
		instr(OP_EXIT, 1, 1'b0);
		check(programCounter, pushA);
		instr(OP_ENA, 1, 1'b0);
		instr(OP_NONE, 1, 1'b0);
		check(interruptEnableFlag, 1'b1);
		instr(OP_MASK, 1, 1'b0);
		check(interruptEnableFlag, 1'b0);
		// request during test-and-clear is seen again and served at its end
		instr(OP_ENA, 1, 1'b0);
		u_req.fire(2);
		instr(OP_TCLR, 2, 1'b1);
		u_req.hold_clear(16);
		check(programCounter, 11'h000);
		check({intPending, interruptEnableFlag}, 2'h0);
		check(outReleaseOe, irc_pkg::OUT_OE_RESET);
		report_and_stop();
	end
endmodule
